// [hw/lsm_top.sv]
// light sensor measurement sequencer with classic wishbone register slave
//
// The placing of the registers and the Wishbone interface to the registers were decided locally.
`timescale 1ns/10ps
module lsm_top
    import lsm_pkg::*;
#(
    parameter int CONV_MIN = CONV_MIN_CYC,
    parameter int CONV_MAX = CONV_MAX_CYC,
    parameter int ARST     = ARST_CYC
) (
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic [7:0]        adr_i,
    input  wire logic [31:0]       dat_i,
    output logic      [31:0]       dat_o,
    input  wire logic              we_i,
    input  wire logic [3:0]        sel_i,
    input  wire logic              cyc_i,
    input  wire logic              stb_i,
    output logic                   ack_o,
    input  wire logic [CODE_W-1:0] light_code_i,
    input  wire logic              int_i,
    output logic                   int_o,
    output logic                   int_oe_o,
    output logic                   irq_o
);
    lsm_state_e        st_q;
    logic [TMR_W-1:0]  tmr_q;
    logic [31:0]       ctrl_q, thr_lo_q, thr_hi_q, dat_q;
    logic [2:0]        sts_q, msk_q;
    logic              ack_q, wr_trig_q, reg_trig_q, int_oe_q;
    logic              int_s1, int_s2, int_s3;
    logic [CODE_W-1:0] code_s1, code_s2;
    logic [3:0]        rng_q, cnt_q, flo_cnt_q, fhi_cnt_q;
    lsm_res_s          res_q [4];
    logic              acc, wr, rd, start, pin_fall, done_p, auto_rng, sat;
    logic [1:0]        mode;
    logic [3:0]        expo, need;
    logic [CODE_W-1:0] shifted, lin;
    logic [MANT_W-1:0] mant;
    logic [31:0]       wdat, rdata;
    lsm_res_s          new_res;

    // twelve conversion lengths
    // conversion length: doubles per step from the shortest, last step is the longest
    function automatic logic [TMR_W-1:0] conv_len(input logic [3:0] k);
        if (k >= CONV_LAST) begin
            return TMR_W'(CONV_MAX);
        end
        return TMR_W'(CONV_MIN) << k;
    endfunction : conv_len

    function automatic logic [3:0] crc4(input logic [27:0] d);
        logic [3:0] c;
        c = 4'h0;
        for (int i = 0; i < 7; i++) begin
            c = c ^ d[i*4 +: 4];
        end
        return c;
    endfunction : crc4

    // wishbone: ack one cycle after the request, writes and read side effects at the ack edge
    assign acc = cyc_i & stb_i & ack_q;
    assign wr  = acc & we_i;
    assign rd  = acc & ~we_i;
    always_comb begin
        for (int b = 0; b < 4; b++) begin
            wdat[b*8 +: 8] = sel_i[b] ? dat_i[b*8 +: 8] : ctrl_q[b*8 +: 8];
        end
    end

    always_comb begin
        rdata = 32'h0000_0000;
        case (adr_i)
            ADR_CTRL:      rdata = ctrl_q;
            ADR_THR_LO:    rdata = thr_lo_q;
            ADR_THR_HI:    rdata = thr_hi_q;
            ADR_STATUS:    rdata = {29'h0, sts_q};
            ADR_MASK:      rdata = {29'h0, msk_q};
            ADR_RES0:      rdata = res_q[0];
            ADR_RES0 + 8'h04: rdata = res_q[1];
            ADR_RES0 + 8'h08: rdata = res_q[2];
            ADR_RES0 + 8'h0C: rdata = res_q[3];
            default:       rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
        end else begin
            ack_q <= cyc_i & stb_i & ~ack_q;
            if (cyc_i & stb_i & ~ack_q) begin
                dat_q <= rdata;
            end
        end
    end
    assign ack_o = ack_q;
    assign dat_o = dat_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            thr_lo_q <= 32'h0000_0000;
            thr_hi_q <= 32'h0FFF_FFFF;
            msk_q    <= 3'h0;
        end else if (wr) begin
            if (adr_i == ADR_THR_LO) begin
                thr_lo_q <= {4'h0, dat_i[CODE_W-1:0]};
            end
            if (adr_i == ADR_THR_HI) begin
                thr_hi_q <= {4'h0, dat_i[CODE_W-1:0]};
            end
            if (adr_i == ADR_MASK) begin
                msk_q <= dat_i[2:0];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q    <= CTRL_RST;
            wr_trig_q <= 1'b0;
        end else begin
            wr_trig_q <= 1'b0;
            if (wr && adr_i == ADR_CTRL) begin
                ctrl_q    <= wdat & CTRL_WMASK;
                wr_trig_q <= (wdat[1:0] == 2'h1) || (wdat[1:0] == 2'h2);
            end else if (done_p && reg_trig_q) begin
                ctrl_q[F_MODE +: 2] <= 2'h0;
            end
        end
    end
    assign mode     = ctrl_q[F_MODE +: 2];
    assign auto_rng = ctrl_q[F_RANGE +: 4] > RANGE_MAX;
    assign need     = 4'h1 << ctrl_q[F_FCNT +: 2];

    // external inputs cross in through two flops; the front end holds its code steady
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            {int_s1, int_s2, int_s3} <= 3'b111;
            code_s1 <= '0;
            code_s2 <= '0;
        end else begin
            {int_s1, int_s2, int_s3} <= {int_i, int_s1, int_s2};
            code_s1 <= light_code_i;
            code_s2 <= code_s1;
        end
    end

    // trigger by write or pin edge
    assign pin_fall = ~ctrl_q[F_INT_DIR] & ~int_s2 & int_s3;
    assign start    = (mode == 2'h3) || ((mode != 2'h0) && (wr_trig_q || pin_fall));
    assign done_p   = (st_q == S_CONV) && (tmr_q == TMR_W'(1)) && (mode != 2'h0);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q       <= S_IDLE;
            tmr_q      <= '0;
            reg_trig_q <= 1'b0;
        end else begin
            case (st_q)
                S_IDLE: begin
                    if (start) begin
                        reg_trig_q <= wr_trig_q && mode != 2'h3;
                        if (mode == 2'h1) begin
                            st_q  <= S_ARST;
                            tmr_q <= TMR_W'(ARST);
                        end else begin
                            st_q  <= S_CONV;
                            tmr_q <= conv_len(ctrl_q[F_CONV +: 4]);
                        end
                    end
                end
                S_ARST: begin
                    tmr_q <= tmr_q - TMR_W'(1);
                    if (mode == 2'h0) begin
                        st_q <= S_IDLE;
                    end else if (tmr_q == TMR_W'(1)) begin
                        st_q  <= S_CONV;
                        tmr_q <= conv_len(ctrl_q[F_CONV +: 4]);
                    end
                end
                S_CONV: begin
                    tmr_q <= tmr_q - TMR_W'(1);
                    if (mode == 2'h0 || tmr_q == TMR_W'(1)) begin
                        st_q <= S_IDLE;
                    end
                end
                default: st_q <= S_IDLE;
            endcase
        end
    end

    assign expo    = auto_rng ? rng_q : ctrl_q[F_RANGE +: 4];
    assign shifted = code_s2 >> expo;
    assign sat     = |shifted[CODE_W-1:MANT_W];
    assign mant    = sat ? {MANT_W{1'b1}} : shifted[MANT_W-1:0];
    assign lin     = CODE_W'(mant) << expo;
    always_comb begin
        new_res      = '0;
        new_res.expo = expo;
        new_res.mant = mant;
        new_res.cnt  = cnt_q;
        new_res.crc  = crc4({expo, mant, cnt_q});
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rng_q <= 4'h0;
        end else if (st_q == S_IDLE && start && mode == 2'h1) begin
            rng_q <= 4'h0;
        end else if (done_p) begin
            if ((sat || mant[MANT_W-1]) && rng_q < RANGE_MAX) begin
                rng_q <= rng_q + 4'h1;
            end else if (mant[MANT_W-1 -: 2] == 2'h0 && rng_q != 4'h0) begin
                rng_q <= rng_q - 4'h1;
            end
        end
    end

    // one update for the whole set
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q <= 4'h0;
        end else if (done_p) begin
            cnt_q <= cnt_q + 4'h1;
        end
    end

    for (genvar i = 0; i < 4; i++) begin : g_hist
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                res_q[i] <= '0;
            end else if (done_p) begin
                res_q[i] <= (i == 0) ? new_res : res_q[(i == 0) ? 0 : i - 1];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flo_cnt_q <= 4'h0;
            fhi_cnt_q <= 4'h0;
        end else if (done_p) begin
            flo_cnt_q <= (lin < thr_lo_q[CODE_W-1:0])
                       ? flo_cnt_q + {3'h0, flo_cnt_q < 4'h8} : 4'h0;
            fhi_cnt_q <= (lin > thr_hi_q[CODE_W-1:0])
                       ? fhi_cnt_q + {3'h0, fhi_cnt_q < 4'h8} : 4'h0;
        end
    end

    // sticky status: only bits already returned by the read are cleared, so a new event wins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sts_q <= 3'h0;
        end else begin
            sts_q <= (sts_q & ~((rd && adr_i == ADR_STATUS) ? dat_q[2:0] : 3'h0))
                   | {done_p && (lin > thr_hi_q[CODE_W-1:0]) && (fhi_cnt_q + 4'h1 >= need),
                      done_p && (lin < thr_lo_q[CODE_W-1:0]) && (flo_cnt_q + 4'h1 >= need),
                      done_p};
        end
    end
    assign irq_o = |(sts_q & msk_q);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            int_oe_q <= 1'b0;
        end else begin
            int_oe_q <= done_p && ctrl_q[F_INT_DIR]
                        && (!ctrl_q[F_INT_CFG] || cnt_q[1:0] == 2'h3);
        end
    end
    // open drain: only ever pulls low
    assign int_o    = 1'b0;
    assign int_oe_o = int_oe_q;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    chk_idle_stop: assert property (mode == 2'h0 |=> st_q != S_CONV)
        else $error("conversion running in mode 0");
    chk_cnt_wrap: assert property (done_p |=> cnt_q == $past(cnt_q) + 4'h1)
        else $error("sample counter did not advance");
    chk_hist_shift: assert property (done_p |=>
        res_q[3] == $past(res_q[2]) && res_q[1] == $past(res_q[0]))
        else $error("history did not shift");
    chk_crc_match: assert property (
        res_q[0].crc == crc4({res_q[0].expo, res_q[0].mant, res_q[0].cnt}))
        else $error("check bits stale");
    chk_range_max: assert property (res_q[0].expo <= RANGE_MAX)
        else $error("range out of bounds");
    chk_int_each: assert property (done_p && ctrl_q[F_INT_DIR] && !ctrl_q[F_INT_CFG]
        |=> int_oe_o ##1 !int_oe_o)
        else $error("missing conversion pulse");
    chk_mode_clear: assert property (done_p && reg_trig_q && !wr |=> mode == 2'h0)
        else $error("one-shot mode not cleared");
    chk_trig_ignore: assert property (st_q == S_CONV && tmr_q > TMR_W'(2)
        && mode != 2'h0 && pin_fall
        |=> st_q == S_CONV && tmr_q == $past(tmr_q) - TMR_W'(1))
        else $error("trigger restarted conversion");
    chk_force_arst: assert property (st_q == S_IDLE && start && mode == 2'h1
        |=> st_q == S_ARST && rng_q == 4'h0)
        else $error("range logic not reset");
    cov_continuous: cover property (mode == 2'h3 && done_p ##[1:3] st_q == S_CONV);
    cov_pin_trig: cover property (pin_fall && st_q == S_IDLE ##1 st_q == S_CONV);
    cov_flag_hi: cover property (sts_q[ST_FHI] && irq_o);
endmodule : lsm_top

// [hw/lsm_pkg.sv]
// light sensor measurement control: shared constants and types
// Operation
// - nine ranges, automatic by default, manual selectable
// - twelve conversion times, 600 us to 800 ms
// - power-up in shutdown, no conversions
// - 4-bit sample counter from 0, wraps after 15
// - check bits refreshed with each result
// - newest result plus three shadows, shift on new
// - interrupt each measurement or every fourth
// - separate low and high thresholds and flags
// - flags set after programmed consecutive faults
// - mode 0: no conversion, bus still answers
// - mode 3: back-to-back conversions, interrupt each or every fourth
// - one-shot: register write or pin edge triggers
// - mode 1: trigger resets auto range, 500 us
// - mode 2: auto range keeps previous history
// - register-triggered one-shot clears mode when done
// - triggers during a conversion are ignored
package lsm_pkg;
    localparam logic [7:0]  ADR_CTRL   = 8'h00;
    localparam logic [7:0]  ADR_THR_LO = 8'h04;
    localparam logic [7:0]  ADR_THR_HI = 8'h08;
    localparam logic [7:0]  ADR_STATUS = 8'h0C;
    localparam logic [7:0]  ADR_MASK   = 8'h10;
    localparam logic [7:0]  ADR_RES0   = 8'h20;
    localparam int          F_MODE     = 0;
    localparam int          F_RANGE    = 2;
    localparam int          F_CONV     = 6;
    localparam int          F_INT_DIR  = 10;
    localparam int          F_INT_CFG  = 11;
    localparam int          F_FCNT     = 12;
    localparam logic [31:0] CTRL_RST   = 32'h0000_0030;
    localparam logic [31:0] CTRL_WMASK = 32'h0000_3FFF;
    localparam logic [3:0]  RANGE_MAX  = 4'h8;
    localparam logic [3:0]  CONV_LAST  = 4'hB;
    localparam int          ST_DONE    = 0;
    localparam int          ST_FLO     = 1;
    localparam int          ST_FHI     = 2;
    localparam int          CLK_MHZ        = 40;
    localparam int          T_CONV_MIN_US  = 600;
    localparam int          T_CONV_MAX_US  = 800000;
    localparam int          T_ARST_US      = 500;
    localparam int          CONV_MIN_CYC   = T_CONV_MIN_US * CLK_MHZ;
    localparam int          CONV_MAX_CYC   = T_CONV_MAX_US * CLK_MHZ;
    localparam int          ARST_CYC       = T_ARST_US * CLK_MHZ;
    localparam int          MANT_W     = 20;
    localparam int          CODE_W     = 28;
    localparam int          TMR_W      = 26;
    typedef struct packed {
        logic [3:0]        expo;
        logic [MANT_W-1:0] mant;
        logic [3:0]        cnt;
        logic [3:0]        crc;
    } lsm_res_s;
    typedef enum logic [2:0] {
        S_IDLE = 3'b001,
        S_ARST = 3'b010,
        S_CONV = 3'b100
    } lsm_state_e;
endpackage : lsm_pkg

// [verification/lsm_front.sv]
// far-side model: light front end and pulled-up interrupt pin
`timescale 1ns/10ps
module lsm_front
    import lsm_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic [CODE_W-1:0] code_i,
    input  wire logic              pull_i,
    input  wire logic              int_o_i,
    input  wire logic              int_oe_i,
    output logic      [CODE_W-1:0] light_code_o,
    output logic                   pin_o
);
    // code moves only on a clock edge, so it is steady through a conversion
    always_ff @(posedge clk_i) begin
        light_code_o <= code_i;
    end
    // pull-up wins unless either party pulls the pin low
    assign pin_o = ~((int_oe_i & ~int_o_i) | pull_i);
endmodule : lsm_front

// [verification/lsm_top_test.sv]
// self-checking testbench for the light sensor measurement sequencer
`timescale 1ns/10ps
module lsm_top_test;
    import lsm_pkg::*;
    localparam int CMIN = 20;
    localparam int CMAX = 400;
    localparam int AR   = 10;
    logic              clk_i  = 1'b0;
    logic              rst_i  = 1'b1;
    logic [7:0]        adr_i  = 8'h00;
    logic [31:0]       dat_i  = 32'h0;
    logic              we_i   = 1'b0;
    logic [3:0]        sel_i  = 4'hF;
    logic              cyc_i  = 1'b0;
    logic              stb_i  = 1'b0;
    logic              pull_q = 1'b0;
    logic [CODE_W-1:0] code_q = 28'h0001000;
    logic [CODE_W-1:0] light_code;
    logic [31:0]       dat_o;
    logic [31:0]       rd;
    logic              ack_o;
    logic              int_o;
    logic              int_oe_o;
    logic              irq_o;
    logic              pin;
    int                err_count  = 0;
    int                n_compared = 0;
    int                n_pulse    = 0;
    int                cyc_n      = 0;

    always #12.5 clk_i = ~clk_i;

    lsm_top #(.CONV_MIN(CMIN), .CONV_MAX(CMAX), .ARST(AR)) dut_u (
        .clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o),
        .we_i(we_i), .sel_i(sel_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
        .light_code_i(light_code), .int_i(pin), .int_o(int_o), .int_oe_o(int_oe_o),
        .irq_o(irq_o));

    lsm_front front_u (.clk_i(clk_i), .code_i(code_q), .pull_i(pull_q), .int_o_i(int_o),
        .int_oe_i(int_oe_o), .light_code_o(light_code), .pin_o(pin));

    always @(posedge clk_i) begin
        cyc_n <= cyc_n + 1;
        if (int_oe_o === 1'b1) begin
            n_pulse <= n_pulse + 1;
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // classic single cycle; waits for ack under a bound
    task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        adr_i <= a;
        we_i  <= w;
        dat_i <= d;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i  <= 1'b0;
        if (n >= 50) check(32'h0, 32'h1);
    endtask : wb

    function automatic logic [3:0] crc(input logic [31:0] v);
        return v[31:28] ^ v[27:24] ^ v[23:20] ^ v[19:16] ^ v[15:12] ^ v[11:8] ^ v[7:4];
    endfunction : crc

    // register one-shot, timed up to its completion pulse
    task automatic shot(input logic [31:0] v, input int len);
        int t0;
        int p0;
        wb(ADR_CTRL, 1'b1, v);
        t0 = cyc_n;
        p0 = n_pulse;
        while (n_pulse == p0 && cyc_n - t0 < len + 40) @(posedge clk_i);
        check(32'(cyc_n - t0 >= len && cyc_n - t0 <= len + 6), 32'h1);
    endtask : shot

    task automatic t_reset();
        wb(ADR_CTRL, 1'b0, 32'h0);
        check(rd, 32'h0000_0030);
        repeat (200) @(posedge clk_i);
        check(32'(n_pulse), 32'h0);
        check({31'h0, int_o}, 32'h0);
        wb(ADR_RES0, 1'b0, 32'h0);
        check(rd, 32'h0);
        wb(8'h40, 1'b0, 32'h0);
        check(rd, 32'h0);
        $display("test reset done");
    endtask : t_reset

    task automatic t_shots();
        shot(32'h0000_0432, CMIN);
        wb(ADR_CTRL, 1'b0, 32'h0);
        check(rd & 32'h3, 32'h0);
        shot(32'h0000_0472, 2 * CMIN);
        shot(32'h0000_06F2, CMAX);
        shot(32'h0000_0431, AR + CMIN);
        for (int r = 0; r <= 8; r += 8) begin
            shot(32'h0000_0402 | 32'(r << 2), CMIN);
            wb(ADR_RES0, 1'b0, 32'h0);
            check(32'(rd[31:28]), 32'(r));
        end
        for (int i = 0; i < 4; i++) begin
            wb(ADR_RES0 + 8'(4 * i), 1'b0, 32'h0);
            check(32'(rd[7:4]), 32'(5 - i));
            check(32'(rd[3:0]), 32'(crc(rd)));
        end
        $display("test one-shot done");
    endtask : t_shots

    // continuous run, then stop; counter and pulses must agree
    task automatic t_cont(input logic cfg4, input int len);
        logic [3:0] c0;
        int p0;
        int e;
        wb(ADR_RES0, 1'b0, 32'h0);
        c0 = rd[7:4];
        p0 = n_pulse;
        wb(ADR_CTRL, 1'b1, 32'h0000_0433 | {20'h0, cfg4, 11'h0});
        repeat (len) @(posedge clk_i);
        wb(ADR_CTRL, 1'b1, 32'h0000_0430);
        repeat (30) @(posedge clk_i);
        wb(ADR_RES0, 1'b0, 32'h0);
        if (!cfg4) begin
            check(32'(rd[7:4]), 32'((c0 + n_pulse - p0) & 15));
            check(32'(n_pulse - p0 >= 16), 32'h1);
        end else begin
            e = 0;
            for (int i = 1; i <= ((rd[7:4] - c0) & 15); i++) begin
                if (((c0 + i) & 3) == 3) e++;
            end
            check(32'(n_pulse - p0), 32'(e));
        end
        $display("test continuous done");
    endtask : t_cont

    task automatic t_pin();
        int p0;
        wb(ADR_RES0, 1'b0, 32'h0);
        p0 = 32'(rd[7:4]);
        wb(ADR_CTRL, 1'b1, 32'h0000_0032);
        repeat (5) @(posedge clk_i);
        pull_q <= 1'b1;
        repeat (4) @(posedge clk_i);
        pull_q <= 1'b0;
        repeat (100) @(posedge clk_i);
        wb(ADR_RES0, 1'b0, 32'h0);
        check(32'(rd[7:4]), 32'((p0 + 1) & 15));
        // mode 2 written while a conversion runs: trigger lost, mode stays armed for the pin
        wb(ADR_CTRL, 1'b1, 32'h0000_0033);
        wb(ADR_CTRL, 1'b1, 32'h0000_0032);
        repeat (40) @(posedge clk_i);
        pull_q <= 1'b1;
        repeat (4) @(posedge clk_i);
        pull_q <= 1'b0;
        repeat (40) @(posedge clk_i);
        wb(ADR_CTRL, 1'b0, 32'h0);
        check(rd & 32'h3, 32'h2);
        wb(ADR_RES0, 1'b0, 32'h0);
        check(32'(rd[7:4]), 32'((p0 + 3) & 15));
        $display("test pin done");
    endtask : t_pin

    task automatic t_thr();
        wb(ADR_THR_HI, 1'b1, 32'h0000_0010);
        wb(ADR_MASK, 1'b1, 32'h0000_0004);
        wb(ADR_STATUS, 1'b0, 32'h0);
        shot(32'h0000_1432, CMIN);
        wb(ADR_STATUS, 1'b0, 32'h0);
        check(rd & 32'h6, 32'h0);
        shot(32'h0000_1432, CMIN);
        check({31'h0, irq_o}, 32'h1);
        wb(ADR_STATUS, 1'b0, 32'h0);
        check(rd & 32'h6, 32'h4);
        @(posedge clk_i);
        check({31'h0, irq_o}, 32'h0);
        wb(ADR_THR_HI, 1'b1, 32'h0FFF_FFFF);
        wb(ADR_THR_LO, 1'b1, 32'h0FFF_FFF0);
        wb(ADR_MASK, 1'b1, 32'h0);
        shot(32'h0000_0432, CMIN);
        check({31'h0, irq_o}, 32'h0);
        wb(ADR_STATUS, 1'b0, 32'h0);
        check(rd & 32'h6, 32'h2);
        $display("test thresholds done");
    endtask : t_thr

    task automatic test_done();
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : test_done

    initial begin
        #(25ns * 20000);
        err_count++;
        test_done();
    end

    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_shots();
        t_cont(1'b0, 420);
        t_cont(1'b1, 150);
        t_pin();
        t_thr();
        test_done();
    end
endmodule : lsm_top_test
